// File: verilog/sfrp_pkg.sv
package sfrp_pkg;
    // Read opcodes
    localparam logic [7:0] SFRP_OP_READ = 8'h03;
    localparam logic [7:0] SFRP_OP_FAST = 8'h0B;
    localparam logic [7:0] SFRP_OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] SFRP_OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] SFRP_OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] SFRP_OP_QUAD_IO = 8'hEB;
    // Continuation byte upper nibble that keeps the opcode-less mode
    localparam logic [3:0] SFRP_CONT_NIBBLE = 4'hA;
    // Phase lengths in bits and clocks
    localparam logic [4:0] SFRP_OPC_BITS = 5'h08;
    localparam logic [4:0] SFRP_ADDR_BITS = 5'h18;
    localparam logic [4:0] SFRP_MODE_BITS = 5'h08;
    localparam logic [3:0] SFRP_DUMMY_FAST = 4'h8;
    localparam logic [3:0] SFRP_DUMMY_QIO = 4'h4;
    localparam logic [3:0] SFRP_DUMMY_NONE = 4'h0;
    localparam logic [3:0] SFRP_BYTE_BITS = 4'h8;
    // Lane width codes: the shift amount of bits per clock
    localparam logic [1:0] SFRP_W1 = 2'h0;
    localparam logic [1:0] SFRP_W2 = 2'h1;
    localparam logic [1:0] SFRP_W4 = 2'h2;
    // Continuation kinds
    localparam logic [1:0] SFRP_CONT_NONE = 2'h0;
    localparam logic [1:0] SFRP_CONT_DUAL = 2'h1;
    localparam logic [1:0] SFRP_CONT_QUAD = 2'h2;
    // Register byte offsets
    localparam logic [7:0] SFRP_CTRL_OFS = 8'h00;
    localparam logic [7:0] SFRP_STAT_OFS = 8'h04;
    localparam logic [7:0] SFRP_ADDR_OFS = 8'h08;
    // Control field positions and reset values
    localparam int SFRP_CTRL_QE_BIT = 0;
    localparam int SFRP_CTRL_BUSY_BIT = 1;
    localparam logic SFRP_QE_RST = 1'b0;
    localparam logic SFRP_BUSY_RST = 1'b0;
    // Status field positions
    localparam int SFRP_STAT_STATE_LSB = 0;
    localparam int SFRP_STAT_CONT_LSB = 4;
    // Transfer phases
    typedef enum logic [2:0] {
        SFRP_OFF = 3'b000,
        SFRP_CMD = 3'b001,
        SFRP_ADDR = 3'b010,
        SFRP_MODE = 3'b011,
        SFRP_DUMMY = 3'b100,
        SFRP_DATA = 3'b101,
        SFRP_IGNORE = 3'b110
    } sfrp_phase_e;
endpackage : sfrp_pkg

// File: verilog/sfrp_read_path.sv
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sfrp_read_path
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Serial link pins
    input wire logic sclk_pin_in,
    input wire logic select_n_pin_in,
    input wire logic [3:0] lane_in,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe_n_out,
    // Memory array read port, one cycle latency
    output logic [23:0] mem_addr_out,
    input wire logic [7:0] mem_data_in
);
    import sfrp_pkg::*;

    typedef struct packed {
        logic [5:0] meta;
        logic [5:0] sync;
        logic sclk_prev;
        sfrp_phase_e phase;
        logic [4:0] cnt;
        logic [23:0] sh;
        logic [1:0] ain_w;
        logic [1:0] dout_w;
        logic has_mode;
        logic [3:0] dummy;
        logic [1:0] kind;
        logic [1:0] cont;
        logic [7:0] ob;
        logic [3:0] rem;
        logic [3:0] lane_o;
        logic [3:0] oe_n;
        logic [23:0] mem_addr;
        logic qe;
        logic busy;
        logic [31:0] prdata;
    } sfrp_state_s;

    sfrp_state_s st_r;
    sfrp_state_s st_nxt;

    // Clocks needed to move a number of bits at the given lane width
    function automatic logic [4:0] sfrp_clocks(input logic [4:0] bits, input logic [1:0] w);
        sfrp_clocks = bits >> w;
    endfunction : sfrp_clocks

    // Shift in one clock's worth of lanes, highest lane holds the higher bit
    function automatic logic [23:0] sfrp_shift(input logic [23:0] sh, input logic [3:0] l,
        input logic [1:0] w);
        if (w == SFRP_W4)
        begin
            sfrp_shift = {sh[19:0], l[3], l[2], l[1], l[0]};
        end
        else if (w == SFRP_W2)
        begin
            sfrp_shift = {sh[21:0], l[1], l[0]};
        end
        else
        begin
            sfrp_shift = {sh[22:0], l[0]};
        end
    endfunction : sfrp_shift

    // Lanes driven for a data width; single lane data leaves on lane one
    function automatic logic [3:0] sfrp_oe_n(input logic [1:0] w);
        if (w == SFRP_W4)
        begin
            sfrp_oe_n = 4'h0;
        end
        else if (w == SFRP_W2)
        begin
            sfrp_oe_n = 4'hC;
        end
        else
        begin
            sfrp_oe_n = 4'hD;
        end
    endfunction : sfrp_oe_n

    // Map the top bits of a byte onto the lanes
    function automatic logic [3:0] sfrp_lanes(input logic [7:0] b, input logic [1:0] w);
        if (w == SFRP_W4)
        begin
            sfrp_lanes = b[7:4];
        end
        else if (w == SFRP_W2)
        begin
            sfrp_lanes = {2'h0, b[7], b[6]};
        end
        else
        begin
            sfrp_lanes = {2'h0, b[7], 1'b0};
        end
    endfunction : sfrp_lanes

    logic sclk_s;
    logic sel_n_s;
    logic [3:0] lanes_s;
    logic rise;
    logic fall;
    logic acc;
    logic [23:0] shv;
    logic [7:0] opc;
    logic [7:0] cur;

    // Only the second sync stage is read by the logic
    assign sclk_s = st_r.sync[0];
    assign sel_n_s = st_r.sync[1];
    assign lanes_s = st_r.sync[5:2];
    assign rise = sclk_s & ~st_r.sclk_prev;
    assign fall = ~sclk_s & st_r.sclk_prev;
    assign acc = psel_in & penable_in;

    // Zero wait state slave, error on unmapped offsets
    always_comb
    begin
        pready_out = 1'b1;
        pslverr_out = acc & (paddr_in != SFRP_CTRL_OFS) & (paddr_in != SFRP_STAT_OFS)
            & (paddr_in != SFRP_ADDR_OFS);
    end

    assign prdata_out = st_r.prdata;
    assign lane_out = st_r.lane_o;
    assign lane_oe_n_out = st_r.oe_n;
    assign mem_addr_out = st_r.mem_addr;

    // Next state of the whole block
    always_comb
    begin
        st_nxt = st_r;
        shv = sfrp_shift(st_r.sh, lanes_s, st_r.ain_w);
        opc = {st_r.sh[6:0], lanes_s[0]};
        cur = mem_data_in;
        st_nxt.meta = {lane_in, select_n_pin_in, sclk_pin_in};
        st_nxt.sync = st_r.meta;
        st_nxt.sclk_prev = sclk_s;

        // Register reads are captured in the setup cycle so data sits in a flop
        if (psel_in & ~penable_in)
        begin
            if (paddr_in == SFRP_CTRL_OFS)
            begin
                st_nxt.prdata = 32'h0;
                st_nxt.prdata[SFRP_CTRL_QE_BIT] = st_r.qe;
                st_nxt.prdata[SFRP_CTRL_BUSY_BIT] = st_r.busy;
            end
            else if (paddr_in == SFRP_STAT_OFS)
            begin
                st_nxt.prdata = 32'h0;
                st_nxt.prdata[SFRP_STAT_STATE_LSB +: 3] = st_r.phase;
                st_nxt.prdata[SFRP_STAT_CONT_LSB +: 2] = st_r.cont;
            end
            else if (paddr_in == SFRP_ADDR_OFS)
            begin
                st_nxt.prdata = {8'h0, st_r.mem_addr};
            end
            else
            begin
                st_nxt.prdata = 32'h0;
            end
        end
        if (acc & pwrite_in & (paddr_in == SFRP_CTRL_OFS))
        begin
            st_nxt.qe = pwdata_in[SFRP_CTRL_QE_BIT];
            st_nxt.busy = pwdata_in[SFRP_CTRL_BUSY_BIT];
        end

        if (sel_n_s)
        begin
            // Select high ends any transfer and floats the lanes
            st_nxt.phase = SFRP_OFF;
            st_nxt.oe_n = 4'hF;
            st_nxt.lane_o = 4'h0;
            st_nxt.cnt = 5'h0;
        end
        else
        begin
            case (st_r.phase)
                SFRP_OFF:
                begin
                    st_nxt.cnt = 5'h0;
                    st_nxt.sh = 24'h0;
                    if (st_r.busy)
                    begin
                        st_nxt.phase = SFRP_IGNORE;
                    end
                    else if (st_r.cont == SFRP_CONT_DUAL)
                    begin
                        // Opcode-less dual transfer
                        st_nxt.phase = SFRP_ADDR;
                        st_nxt.ain_w = SFRP_W2;
                        st_nxt.dout_w = SFRP_W2;
                        st_nxt.has_mode = 1'b1;
                        st_nxt.dummy = SFRP_DUMMY_NONE;
                        st_nxt.kind = SFRP_CONT_DUAL;
                    end
                    else if ((st_r.cont == SFRP_CONT_QUAD) && st_r.qe)
                    begin
                        // Opcode-less quad transfer, taken only while quad enable is still set
                        st_nxt.phase = SFRP_ADDR;
                        st_nxt.ain_w = SFRP_W4;
                        st_nxt.dout_w = SFRP_W4;
                        st_nxt.has_mode = 1'b1;
                        st_nxt.dummy = SFRP_DUMMY_QIO;
                        st_nxt.kind = SFRP_CONT_QUAD;
                    end
                    else
                    begin
                        st_nxt.phase = SFRP_CMD;
                    end
                end
                SFRP_CMD:
                begin
                    if (rise)
                    begin
                        st_nxt.sh = {st_r.sh[22:0], lanes_s[0]};
                        st_nxt.cnt = st_r.cnt + 5'h1;
                        if (st_r.cnt + 5'h1 == SFRP_OPC_BITS)
                        begin
                            st_nxt.cnt = 5'h0;
                            st_nxt.phase = SFRP_ADDR;
                            st_nxt.ain_w = SFRP_W1;
                            st_nxt.dout_w = SFRP_W1;
                            st_nxt.has_mode = 1'b0;
                            st_nxt.dummy = SFRP_DUMMY_NONE;
                            st_nxt.kind = SFRP_CONT_NONE;
                            if (opc == SFRP_OP_READ)
                            begin
                                st_nxt.dummy = SFRP_DUMMY_NONE;
                            end
                            else if (opc == SFRP_OP_FAST)
                            begin
                                st_nxt.dummy = SFRP_DUMMY_FAST;
                            end
                            else if (opc == SFRP_OP_DUAL_OUT)
                            begin
                                st_nxt.dummy = SFRP_DUMMY_FAST;
                                st_nxt.dout_w = SFRP_W2;
                            end
                            else if ((opc == SFRP_OP_QUAD_OUT) && st_r.qe)
                            begin
                                st_nxt.dummy = SFRP_DUMMY_FAST;
                                st_nxt.dout_w = SFRP_W4;
                            end
                            else if (opc == SFRP_OP_DUAL_IO)
                            begin
                                st_nxt.ain_w = SFRP_W2;
                                st_nxt.dout_w = SFRP_W2;
                                st_nxt.has_mode = 1'b1;
                                st_nxt.kind = SFRP_CONT_DUAL;
                            end
                            else if ((opc == SFRP_OP_QUAD_IO) && st_r.qe)
                            begin
                                st_nxt.ain_w = SFRP_W4;
                                st_nxt.dout_w = SFRP_W4;
                                st_nxt.has_mode = 1'b1;
                                st_nxt.dummy = SFRP_DUMMY_QIO;
                                st_nxt.kind = SFRP_CONT_QUAD;
                            end
                            else
                            begin
                                // Unknown opcode, or quad read without quad enable
                                st_nxt.phase = SFRP_IGNORE;
                            end
                        end
                    end
                end
                SFRP_ADDR:
                begin
                    if (rise)
                    begin
                        st_nxt.sh = shv;
                        st_nxt.cnt = st_r.cnt + 5'h1;
                        if (st_r.cnt + 5'h1 == sfrp_clocks(SFRP_ADDR_BITS, st_r.ain_w))
                        begin
                            st_nxt.cnt = 5'h0;
                            st_nxt.mem_addr = shv;
                            if (st_r.has_mode)
                            begin
                                st_nxt.phase = SFRP_MODE;
                            end
                            else if (st_r.dummy != SFRP_DUMMY_NONE)
                            begin
                                st_nxt.phase = SFRP_DUMMY;
                            end
                            else
                            begin
                                st_nxt.phase = SFRP_DATA;
                                st_nxt.rem = 4'h0;
                            end
                        end
                    end
                end
                SFRP_MODE:
                begin
                    if (rise)
                    begin
                        st_nxt.sh = shv;
                        st_nxt.cnt = st_r.cnt + 5'h1;
                        if (st_r.cnt + 5'h1 == sfrp_clocks(SFRP_MODE_BITS, st_r.ain_w))
                        begin
                            st_nxt.cnt = 5'h0;
                            // Only the upper nibble is judged
                            if (shv[7:4] == SFRP_CONT_NIBBLE)
                            begin
                                st_nxt.cont = st_r.kind;
                            end
                            else
                            begin
                                st_nxt.cont = SFRP_CONT_NONE;
                            end
                            st_nxt.phase = (st_r.dummy != SFRP_DUMMY_NONE) ? SFRP_DUMMY
                                : SFRP_DATA;
                            st_nxt.rem = 4'h0;
                        end
                    end
                end
                SFRP_DUMMY:
                begin
                    // Lanes stay floating, so nothing meaningful is shown
                    if (rise)
                    begin
                        st_nxt.cnt = st_r.cnt + 5'h1;
                        if (st_r.cnt[3:0] + 4'h1 == st_r.dummy)
                        begin
                            st_nxt.cnt = 5'h0;
                            st_nxt.phase = SFRP_DATA;
                            st_nxt.rem = 4'h0;
                        end
                    end
                end
                SFRP_DATA:
                begin
                    // Memory word for mem_addr is fetched long before the next fall
                    if (fall)
                    begin
                        st_nxt.oe_n = sfrp_oe_n(st_r.dout_w);
                        if (st_r.rem == 4'h0)
                        begin
                            st_nxt.lane_o = sfrp_lanes(cur, st_r.dout_w);
                            st_nxt.ob = cur << (4'h1 << st_r.dout_w);
                            st_nxt.rem = SFRP_BYTE_BITS - (4'h1 << st_r.dout_w);
                            st_nxt.mem_addr = st_r.mem_addr + 24'h1;
                        end
                        else
                        begin
                            st_nxt.lane_o = sfrp_lanes(st_r.ob, st_r.dout_w);
                            st_nxt.ob = st_r.ob << (4'h1 << st_r.dout_w);
                            st_nxt.rem = st_r.rem - (4'h1 << st_r.dout_w);
                        end
                    end
                end
                default:
                begin
                    // Ignored instruction waits for select to rise
                    st_nxt.oe_n = 4'hF;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            // Serial clock stages reset to its idle low level, so no false edge follows
            st_r <= '{meta: 6'h3E, sync: 6'h3E, sclk_prev: 1'b0, phase: SFRP_OFF,
                cnt: 5'h0, sh: 24'h0, ain_w: SFRP_W1, dout_w: SFRP_W1, has_mode: 1'b0,
                dummy: SFRP_DUMMY_NONE, kind: SFRP_CONT_NONE, cont: SFRP_CONT_NONE,
                ob: 8'h0, rem: 4'h0, lane_o: 4'h0, oe_n: 4'hF, mem_addr: 24'h0,
                qe: SFRP_QE_RST, busy: SFRP_BUSY_RST, prdata: 32'h0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule : sfrp_read_path
`default_nettype wire

// File: verif/sfrp_read_path_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sfrp_read_path_checker
    import sfrp_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Serial link pins
    input wire logic sclk_pin_in,
    input wire logic select_n_pin_in,
    input wire logic [3:0] lane_in,
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe_n_out,
    // Memory port
    input wire logic [23:0] mem_addr_out,
    input wire logic [7:0] mem_data_in
);
    logic qe_r;
    logic busy_r;
    logic blk_r;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // Shadow of CTRL; busy latched while deselected, as the device judges it at select fall
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            qe_r <= SFRP_QE_RST;
            busy_r <= SFRP_BUSY_RST;
            blk_r <= 1'b0;
        end
        else
        begin
            qe_r <= (psel_in && penable_in && pwrite_in && paddr_in == SFRP_CTRL_OFS) ?
                pwdata_in[SFRP_CTRL_QE_BIT] : qe_r;
            busy_r <= (psel_in && penable_in && pwrite_in && paddr_in == SFRP_CTRL_OFS) ?
                pwdata_in[SFRP_CTRL_BUSY_BIT] : busy_r;
            blk_r <= select_n_pin_in ? busy_r : blk_r;
        end
    end
    a_float_idle: assert property (select_n_pin_in [*6] |-> lane_oe_n_out == 4'hF)
        else $error("lanes driven while deselected");
    a_stop_select: assert property ($rose(select_n_pin_in) |-> ##[1:6] lane_oe_n_out == 4'hF)
        else $error("output kept after select rose");
    a_quad_gate: assert property (!qe_r |-> lane_oe_n_out[3:2] == 2'b11)
        else $error("quad lanes driven with quad enable clear");
    a_busy_block: assert property (blk_r && !select_n_pin_in |-> lane_oe_n_out == 4'hF)
        else $error("read answered while busy");
    a_quad_together: assert property (!lane_oe_n_out[2] |-> lane_oe_n_out == 4'h0)
        else $error("quad lanes not driven together");
    a_dual_pair: assert property (!lane_oe_n_out[0] |-> !lane_oe_n_out[1])
        else $error("lane zero driven without lane one");
    a_fall_launch: assert property (!select_n_pin_in && !lane_oe_n_out[1] &&
        !$past(lane_oe_n_out[1]) && !$stable(lane_out) |-> !$past(sclk_pin_in, 2))
        else $error("data changed away from a falling edge");
    a_addr_step: assert property (!select_n_pin_in && !lane_oe_n_out[1] &&
        !$past(lane_oe_n_out[1]) && !$stable(mem_addr_out) |->
        mem_addr_out == $past(mem_addr_out) + 24'h000001)
        else $error("address did not step by one");
    c_quad: cover property (lane_oe_n_out == 4'h0);
    c_dual: cover property (lane_oe_n_out == 4'hC);
    c_step: cover property (!lane_oe_n_out[1] && !$stable(mem_addr_out));
endmodule : sfrp_read_path_checker
bind sfrp_read_path sfrp_read_path_checker chk_u (.mclk_in(mclk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .sclk_pin_in(sclk_pin_in), .select_n_pin_in(select_n_pin_in),
    .lane_in(lane_in), .lane_out(lane_out), .lane_oe_n_out(lane_oe_n_out),
    .mem_addr_out(mem_addr_out), .mem_data_in(mem_data_in));
`default_nettype wire

// File: verif/sfrp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfrp_host_model
(
    // Device side of the lanes
    input wire logic [3:0] dev_lane_in,
    input wire logic [3:0] dev_oe_n_in,
    // Link pins toward the device
    output logic sclk_out,
    output logic select_n_out,
    output logic [3:0] lane_out
);
    logic [3:0] hval;
    logic [3:0] hen = 4'h0;
    logic [3:0] junk = 4'h5;
    logic [31:0] acc;
    bit drove;
    initial
    begin
        sclk_out = 1'b0;
        select_n_out = 1'b1;
    end
    // Wire level; a floating lane wanders so a stale value never passes
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            lane_out[i] = !dev_oe_n_in[i] ? dev_lane_in[i] : (hen[i] ? hval[i] : junk[i]);
    end
    // Any device drive inside a frame is remembered
    always @(dev_oe_n_in)
        if (dev_oe_n_in != 4'hF && !select_n_out)
            drove = 1'b1;
    // One link clock; the host lets go 50 ns after the rise, well before the next fall
    task clk1(input logic [31:0] v, input int w, input logic [3:0] en);
        hval = w == 1 ? {3'h0, v[31]} : (w == 2 ? {2'h0, v[31:30]} : v[31:28]);
        hen = en;
        #100;
        acc = (acc << w) | (w == 1 ? {31'h0, lane_out[1]} :
            (w == 2 ? {30'h0, lane_out[1:0]} : {28'h0, lane_out}));
        sclk_out = 1'b1;
        #50;
        hen = 4'h0;
        junk = ~junk;
        #50;
        sclk_out = 1'b0;
    endtask : clk1
    task send(input logic [31:0] v, input int n, input int w, input bit drv);
        for (int i = 0; i < n; i++)
        begin
            clk1(v, w, drv ? (w == 1 ? 4'h1 : (w == 2 ? 4'h3 : 4'hF)) : 4'h0);
            v = v << w;
        end
    endtask : send
    // Whole read frame; returns the bytes seen and whether the device drove
    task read_xfer(input logic [7:0] op, input bit sop, input logic [23:0] a,
        input logic [7:0] m, input int n, output logic [31:0] got, output bit dr);
        int aw;
        int dw;
        aw = op == 8'hBB ? 2 : (op == 8'hEB ? 4 : 1);
        dw = (op == 8'h3B || op == 8'hBB) ? 2 : ((op == 8'h6B || op == 8'hEB) ? 4 : 1);
        #7;
        drove = 1'b0;
        select_n_out = 1'b0;
        if (sop)
            send({op, 24'h0}, 8, 1, 1'b1);
        send({a, 8'h0}, 24 / aw, aw, 1'b1);
        if (aw > 1)
            send({m, 24'h0}, 8 / aw, aw, 1'b1);
        if (op != 8'h03)
            send(32'h0, aw == 2 ? 0 : (aw == 4 ? 4 : 8), 1, 1'b0);
        acc = 32'h0;
        send(32'h0, n * 8 / dw, dw, 1'b0);
        got = acc;
        dr = drove;
        select_n_out = 1'b1;
        #400;
    endtask : read_xfer
endmodule : sfrp_host_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sfrp_pkg::*;
    localparam logic [7:0] WIDE_OPS [5] = '{SFRP_OP_FAST, SFRP_OP_DUAL_OUT,
        SFRP_OP_QUAD_OUT, SFRP_OP_DUAL_IO, SFRP_OP_QUAD_IO};
    // Performance mode command; not a read, so the device must stay silent
    localparam logic [7:0] HIGH_PERF_MODE_CMD = 8'hA3;
    logic mclk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sclk;
    logic select_n;
    logic [3:0] lane_in;
    logic [3:0] lane_out;
    logic [3:0] lane_oe_n;
    logic [23:0] mem_addr;
    logic [7:0] mem_data = 8'h00;
    logic [31:0] rd;
    logic err;
    int mismatches = 0;
    int cmp_count = 0;
    sfrp_read_path dut_u (.mclk_in(mclk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .sclk_pin_in(sclk),
        .select_n_pin_in(select_n), .lane_in(lane_in), .lane_out(lane_out),
        .lane_oe_n_out(lane_oe_n), .mem_addr_out(mem_addr), .mem_data_in(mem_data));
    sfrp_host_model host_u (.dev_lane_in(lane_out), .dev_oe_n_in(lane_oe_n),
        .sclk_out(sclk), .select_n_out(select_n), .lane_out(lane_in));
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Memory contents follow the address; one cycle read latency
    function automatic logic [7:0] mval(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
    endfunction : mval
    always @(posedge mclk)
        mem_data <= mval(mem_addr);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // APB transfer; waits for pready, watchdog cuts a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic spi_chk(input logic [7:0] op, input bit sop, input logic [23:0] a,
        input logic [7:0] m, input int n, input bit live);
        logic [31:0] exp;
        logic [31:0] got;
        bit dr;
        exp = 32'h0;
        for (int i = 0; i < n; i++)
            exp = {exp[23:0], mval(a + 24'(i))};
        host_u.read_xfer(op, sop, a, m, n, got, dr);
        chk({31'h0, dr}, {31'h0, live});
        if (live)
            chk(got, exp);
    endtask : spi_chk
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // Watchdog, about seven times the expected run
    initial
    begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        complete_run();
    end
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        // Reset values, read-only status, unmapped offset
        apb(1'b0, SFRP_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, SFRP_STAT_OFS, 32'hFFFFFFFF);
        apb(1'b0, SFRP_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // Plain read across the top of memory
        spi_chk(SFRP_OP_READ, 1'b1, 24'hFFFFFE, 8'h00, 4, 1'b1);
        apb(1'b0, SFRP_ADDR_OFS, 32'h0);
        chk(rd, 32'h2);
        // Every fast form with quad enable set
        apb(1'b1, SFRP_CTRL_OFS, 32'h1);
        spi_chk(HIGH_PERF_MODE_CMD, 1'b1, 24'h000000, 8'h00, 1, 1'b0);
        for (int i = 0; i < 5; i++)
            spi_chk(WIDE_OPS[i], 1'b1, 24'h5A5A00 + 24'(i * 273), 8'h00, 3, 1'b1);
        // Dual continuation kept, then dropped
        spi_chk(SFRP_OP_DUAL_IO, 1'b1, 24'h00ABC0, 8'hA5, 2, 1'b1);
        apb(1'b0, SFRP_STAT_OFS, 32'h0);
        chk(rd & 32'h30, 32'h10);
        spi_chk(SFRP_OP_DUAL_IO, 1'b0, 24'h0F0F01, 8'h3A, 2, 1'b1);
        spi_chk(SFRP_OP_READ, 1'b1, 24'h000100, 8'h00, 1, 1'b1);
        // Quad continuation kept, then dropped
        spi_chk(SFRP_OP_QUAD_IO, 1'b1, 24'h123456, 8'hA3, 2, 1'b1);
        spi_chk(SFRP_OP_QUAD_IO, 1'b0, 24'h654321, 8'h5A, 2, 1'b1);
        spi_chk(SFRP_OP_FAST, 1'b1, 24'h00FFFF, 8'h00, 2, 1'b1);
        // Busy refuses reads; quad forms refused without quad enable
        apb(1'b1, SFRP_CTRL_OFS, 32'h2);
        spi_chk(SFRP_OP_READ, 1'b1, 24'h000010, 8'h00, 2, 1'b0);
        apb(1'b1, SFRP_CTRL_OFS, 32'h0);
        spi_chk(SFRP_OP_QUAD_OUT, 1'b1, 24'h000020, 8'h00, 2, 1'b0);
        spi_chk(SFRP_OP_QUAD_IO, 1'b1, 24'h000030, 8'h00, 2, 1'b0);
        spi_chk(SFRP_OP_READ, 1'b1, 24'h000010, 8'h00, 2, 1'b1);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
